// ---- common/cmpref_pkg.sv ----
// Package of register map, field positions and reset values for the comparator/reference block
//
// Behaviour
// RULE1: Stop-in-idle set disables all comparators in Idle; clear keeps them running.
// RULE2: Status bits 2..0 show live outputs of comparators three, two, one.
// RULE3: Status bits 31..14 and 12..3 always read zero.
// RULE4: Reference control answers at +4, +8, +C as clear, set, invert aliases.
// RULE5: Four-bit tap select picks one of sixteen ladder levels in each range.
// RULE6: Control bit five selects high or low reference range.
// RULE7: Control bit four selects supply rails or external reference as ladder source.
// RULE8: Control bit fifteen powers the ladder up; clear powers it down.
// RULE9: Bit six drives reference to pin; comparator connection always kept.
// RULE10: Any reset clears reference control to all zeros.
// RULE11: Writes to unimplemented bits have no effect and they read zero.
package cmpref_pkg;
    localparam int          ADDR_W          = 16;
    localparam int          DATA_W          = 32;
    // Byte addresses within the block window
    localparam logic [15:0] REF_CTRL_ADDR   = 16'h9800;
    localparam logic [15:0] CMP_STAT_ADDR   = 16'h9810;
    localparam logic [15:0] ALIAS_CLR_OFS   = 16'h0004;
    localparam logic [15:0] ALIAS_SET_OFS   = 16'h0008;
    localparam logic [15:0] ALIAS_INV_OFS   = 16'h000C;
    // Field positions
    localparam int          STOP_IDLE_BIT   = 13;
    localparam int          LADDER_EN_BIT   = 15;
    localparam int          PIN_OE_BIT      = 6;
    localparam int          RANGE_BIT       = 5;
    localparam int          SUPPLY_BIT      = 4;
    localparam int          TAP_LSB         = 0;
    localparam int          TAP_W           = 4;
    localparam int          NUM_CMP         = 3;
    // Writable masks and reset values
    localparam logic [31:0] REF_CTRL_MASK   = 32'h0000_807F;
    localparam logic [31:0] CMP_STAT_WMASK  = 32'h0000_2000;
    localparam logic [31:0] REF_CTRL_RESET  = 32'h0000_0000;
    localparam logic [31:0] CMP_STAT_RESET  = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    // Write operation kinds
    typedef enum logic [1:0] {CMPREF_WR_PLAIN, CMPREF_WR_CLR, CMPREF_WR_SET, CMPREF_WR_INV} cmpref_wop_t;
endpackage

// ---- common/cmpref_reg_if.sv ----
// Internal register access carrier between bus slave and register file
`timescale 1ns/1ps
interface cmpref_reg_if;
    import cmpref_pkg::*;
    logic        wr_en;
    logic [15:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_hit;
    logic [15:0] rd_addr;
    logic [31:0] rd_data;
    logic        rd_hit;
    modport bus (output wr_en, output wr_addr, output wr_data, output wr_strb,
                 input wr_hit, output rd_addr, input rd_data, input rd_hit);
    modport regs (input wr_en, input wr_addr, input wr_data, input wr_strb,
                  output wr_hit, input rd_addr, output rd_data, output rd_hit);
endinterface

// ---- hdl/cmpref_axil_slave.sv ----
// AXI4-Lite slave front end, one write and one read at a time
`timescale 1ns/1ps
module cmpref_axil_slave
    import cmpref_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    input  wire logic [15:0] awaddr_i,
    input  wire logic        awvalid_i,
    output logic             awready_o,
    input  wire logic [31:0] wdata_i,
    input  wire logic [3:0]  wstrb_i,
    input  wire logic        wvalid_i,
    output logic             wready_o,
    output logic [1:0]       bresp_o,
    output logic             bvalid_o,
    input  wire logic        bready_i,
    input  wire logic [15:0] araddr_i,
    input  wire logic        arvalid_i,
    output logic             arready_o,
    output logic [31:0]      rdata_o,
    output logic [1:0]       rresp_o,
    output logic             rvalid_o,
    input  wire logic        rready_i,
    cmpref_reg_if.bus        rif
);
    logic        aw_held;
    logic        w_held;
    logic [15:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    // Address and data may arrive in either order; each latched separately
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 16'h0000;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else if (rif.wr_en) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
        end else begin
            if (awvalid_i && awready_o) begin
                aw_held <= 1'b1;
                aw_addr <= awaddr_i;
            end
            if (wvalid_i && wready_o) begin
                w_held <= 1'b1;
                w_data <= wdata_i;
                w_strb <= wstrb_i;
            end
        end
    end

    // Ready flags registered: each mirrors its half being free and no response pending
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            awready_o <= 1'b1;
            wready_o  <= 1'b1;
        end else if (rif.wr_en) begin
            awready_o <= 1'b0;
            wready_o  <= 1'b0;
        end else if (bvalid_o && bready_i) begin
            awready_o <= 1'b1;
            wready_o  <= 1'b1;
        end else begin
            if (awvalid_i && awready_o) begin
                awready_o <= 1'b0;
            end
            if (wvalid_i && wready_o) begin
                wready_o <= 1'b0;
            end
        end
    end
    assign rif.wr_en   = aw_held && w_held && !bvalid_o;
    assign rif.wr_addr = aw_addr;
    assign rif.wr_data = w_data;
    assign rif.wr_strb = w_strb;

    // Write response one cycle after both halves are in
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bvalid_o <= 1'b0;
            bresp_o  <= RESP_OKAY;
        end else if (rif.wr_en) begin
            bvalid_o <= 1'b1;
            bresp_o  <= rif.wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_o && bready_i) begin
            bvalid_o <= 1'b0;
        end
    end

    // Read answered the cycle after the address is taken
    assign rif.rd_addr = araddr_i;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rvalid_o  <= 1'b0;
            arready_o <= 1'b1;
            rdata_o   <= 32'h0000_0000;
            rresp_o   <= RESP_OKAY;
        end else if (arvalid_i && arready_o) begin
            rvalid_o  <= 1'b1;
            arready_o <= 1'b0;
            rdata_o   <= rif.rd_hit ? rif.rd_data : 32'h0000_0000;
            rresp_o   <= rif.rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_o && rready_i) begin
            rvalid_o  <= 1'b0;
            arready_o <= 1'b1;
        end
    end

    // Response waits for both halves of a write
    a_bresp_after_both: assert property (@(posedge clock_i) disable iff (!resetn_i)
        $rose(bvalid_o) |-> $past(aw_held) && $past(w_held))
        else $error("write response without address and data");
    // Read data held until accepted
    a_rdata_held_stable: assert property (@(posedge clock_i) disable iff (!resetn_i)
        rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
        else $error("read data dropped before accept");
endmodule // cmpref_axil_slave

// ---- hdl/cmpref_regs.sv ----
// Register file: status, stop-in-idle, reference ladder control with aliases
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module cmpref_regs
    import cmpref_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    input  wire logic [2:0]  cmp_out_i,
    input  wire logic        idle_i,
    cmpref_reg_if.regs       rif,
    output logic             stop_in_idle_o,
    output logic             cmp_enable_o,
    output logic             ladder_enable_o,
    output logic             ladder_pin_output_enable_o,
    output logic             ladder_range_select_o,
    output logic             ladder_supply_select_o,
    output logic [3:0]       ladder_tap_select_o,
    output logic             ladder_cmp_connect_o
);
    logic [31:0] reference_ladder_control;
    logic [31:0] comparator_status;
    logic [31:0] next_ref;
    logic [31:0] wmask;
    logic [15:0] ofs;
    logic        ref_hit;
    logic        stat_hit;
    cmpref_wop_t wop;
    logic [2:0]  cmp_meta;
    logic [2:0]  cmp_sync;

    // Byte-lane mask from strobes, one per lane
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign wmask[g*8 +: 8] = {8{rif.wr_strb[g]}};
        end
    endgenerate

    // Decode: base plus three aliases for the control register
    always_comb begin
        ofs      = rif.wr_addr - REF_CTRL_ADDR;
        ref_hit  = (rif.wr_addr[15:4] == REF_CTRL_ADDR[15:4]) && (rif.wr_addr[1:0] == 2'h0);
        stat_hit = (rif.wr_addr == CMP_STAT_ADDR);
        case (ofs[3:0])
            ALIAS_CLR_OFS[3:0]: wop = CMPREF_WR_CLR;   // RULE4
            ALIAS_SET_OFS[3:0]: wop = CMPREF_WR_SET;   // RULE4
            ALIAS_INV_OFS[3:0]: wop = CMPREF_WR_INV;   // RULE4
            default:            wop = CMPREF_WR_PLAIN;
        endcase
    end
    assign rif.wr_hit = ref_hit || stat_hit;

    // Only implemented bits ever change
    always_comb begin
        next_ref = reference_ladder_control;
        case (wop)
            CMPREF_WR_CLR: next_ref = reference_ladder_control & ~(rif.wr_data & wmask); // RULE4
            CMPREF_WR_SET: next_ref = reference_ladder_control | (rif.wr_data & wmask);  // RULE4
            CMPREF_WR_INV: next_ref = reference_ladder_control ^ (rif.wr_data & wmask);  // RULE4
            default:       next_ref = (reference_ladder_control & ~wmask) | (rif.wr_data & wmask);
        endcase
        next_ref = next_ref & REF_CTRL_MASK; // RULE11
    end

    // Control register, zero on reset
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reference_ladder_control <= REF_CTRL_RESET; // RULE10
        end else if (rif.wr_en && ref_hit) begin
            reference_ladder_control <= next_ref;
        end
    end

    // Stop-in-idle bit; other status bits not writable
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stop_in_idle_o <= 1'b0;
        end else if (rif.wr_en && stat_hit && rif.wr_strb[STOP_IDLE_BIT/8]) begin
            stop_in_idle_o <= rif.wr_data[STOP_IDLE_BIT]; // RULE11
        end
    end

    // Comparator outputs are asynchronous, two-stage synchroniser
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmp_meta <= 3'h0;
            cmp_sync <= 3'h0;
        end else begin
            cmp_meta <= cmp_out_i;
            cmp_sync <= cmp_meta;
        end
    end

    // Status word: live outputs low, stop-in-idle at its bit, rest zero
    always_comb begin
        comparator_status = CMP_STAT_RESET;                   // RULE3
        comparator_status[NUM_CMP-1:0] = cmp_sync;            // RULE2
        comparator_status[STOP_IDLE_BIT] = stop_in_idle_o;
    end

    // Read mux; aliases read back the control value
    always_comb begin
        rif.rd_hit  = 1'b0;
        rif.rd_data = 32'h0000_0000;
        if (rif.rd_addr[15:4] == REF_CTRL_ADDR[15:4] && rif.rd_addr[1:0] == 2'h0) begin
            rif.rd_hit  = 1'b1;
            rif.rd_data = reference_ladder_control;
        end else if (rif.rd_addr == CMP_STAT_ADDR) begin
            rif.rd_hit  = 1'b1;
            rif.rd_data = comparator_status;
        end
    end

    // Analog controls, registered
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmp_enable_o               <= 1'b1;
            ladder_enable_o            <= 1'b0;
            ladder_pin_output_enable_o <= 1'b0;
            ladder_range_select_o      <= 1'b0;
            ladder_supply_select_o     <= 1'b0;
            ladder_tap_select_o        <= 4'h0;
            ladder_cmp_connect_o       <= 1'b1;
        end else begin
            cmp_enable_o <= !(idle_i && stop_in_idle_o);                          // RULE1
            ladder_enable_o <= reference_ladder_control[LADDER_EN_BIT];            // RULE8
            ladder_pin_output_enable_o <= reference_ladder_control[PIN_OE_BIT];    // RULE9
            ladder_range_select_o <= reference_ladder_control[RANGE_BIT];          // RULE6
            ladder_supply_select_o <= reference_ladder_control[SUPPLY_BIT];        // RULE7
            ladder_tap_select_o <= reference_ladder_control[TAP_LSB +: TAP_W];     // RULE5
            ladder_cmp_connect_o <= 1'b1;                                          // RULE9
        end
    end

    a_idle_stops_cmp: assert property (@(posedge clock_i) disable iff (!resetn_i)
        idle_i && stop_in_idle_o |=> !cmp_enable_o) // RULE1
        else $error("comparators not stopped in idle");
    a_run_in_idle: assert property (@(posedge clock_i) disable iff (!resetn_i)
        !stop_in_idle_o |=> cmp_enable_o) // RULE1
        else $error("comparators stopped without stop-in-idle");
    // Synchroniser still holds reset zeros for two edges after release
    a_status_live: assert property (@(posedge clock_i) disable iff (!resetn_i)
        $past(resetn_i) && $past(resetn_i, 2)
        |-> comparator_status[2:0] == $past(cmp_out_i, 2)) // RULE2
        else $error("status does not follow comparator outputs");
    a_status_zeros: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (comparator_status & ~32'h0000_2007) == 32'h0000_0000) // RULE3
        else $error("unimplemented status bit set");
    a_alias_set: assert property (@(posedge clock_i) disable iff (!resetn_i)
        rif.wr_en && ref_hit && wop == CMPREF_WR_SET && rif.wr_strb == 4'hF
        |=> (reference_ladder_control & ($past(rif.wr_data) & REF_CTRL_MASK))
            == ($past(rif.wr_data) & REF_CTRL_MASK)) // RULE4
        else $error("set alias did not set bits");
    a_alias_clr: assert property (@(posedge clock_i) disable iff (!resetn_i)
        rif.wr_en && ref_hit && wop == CMPREF_WR_CLR && rif.wr_strb == 4'hF
        |=> (reference_ladder_control & $past(rif.wr_data)) == 32'h0000_0000) // RULE4
        else $error("clear alias did not clear bits");
    a_tap_follows: assert property (@(posedge clock_i) disable iff (!resetn_i)
        ladder_tap_select_o == $past(reference_ladder_control[3:0])
        && ladder_range_select_o == $past(reference_ladder_control[5])) // RULE5
        else $error("tap or range output wrong");
    a_enable_follows: assert property (@(posedge clock_i) disable iff (!resetn_i)
        ladder_enable_o == $past(reference_ladder_control[15])
        && ladder_supply_select_o == $past(reference_ladder_control[4])) // RULE8
        else $error("enable or supply output wrong");
    a_pin_keeps_cmp: assert property (@(posedge clock_i) disable iff (!resetn_i)
        ladder_cmp_connect_o && ladder_pin_output_enable_o == $past(reference_ladder_control[6]))
        // RULE9
        else $error("pin enable or comparator link wrong");
    a_ctrl_masked: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (reference_ladder_control & ~REF_CTRL_MASK) == 32'h0000_0000) // RULE11
        else $error("unimplemented control bit set");
endmodule // cmpref_regs

// ---- hdl/cmpref_top.sv ----
// Top: comparator status and reference ladder control over AXI4-Lite
`timescale 1ns/1ps
module cmpref_top
    import cmpref_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    input  wire logic [15:0] s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [15:0] s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    input  wire logic        cmp_one_output_i,
    input  wire logic        cmp_two_output_i,
    input  wire logic        cmp_three_output_i,
    input  wire logic        idle_i,
    output logic             stop_in_idle_o,
    output logic             cmp_enable_o,
    output logic             ladder_enable_o,
    output logic             ladder_pin_output_enable_o,
    output logic             ladder_range_select_o,
    output logic             ladder_supply_select_o,
    output logic [3:0]       ladder_tap_select_o,
    output logic             ladder_cmp_connect_o
);
    cmpref_reg_if rif ();

    cmpref_axil_slave u_bus (
        .clock_i   (clock_i),
        .resetn_i  (resetn_i),
        .awaddr_i  (s_axi_awaddr_i),
        .awvalid_i (s_axi_awvalid_i),
        .awready_o (s_axi_awready_o),
        .wdata_i   (s_axi_wdata_i),
        .wstrb_i   (s_axi_wstrb_i),
        .wvalid_i  (s_axi_wvalid_i),
        .wready_o  (s_axi_wready_o),
        .bresp_o   (s_axi_bresp_o),
        .bvalid_o  (s_axi_bvalid_o),
        .bready_i  (s_axi_bready_i),
        .araddr_i  (s_axi_araddr_i),
        .arvalid_i (s_axi_arvalid_i),
        .arready_o (s_axi_arready_o),
        .rdata_o   (s_axi_rdata_o),
        .rresp_o   (s_axi_rresp_o),
        .rvalid_o  (s_axi_rvalid_o),
        .rready_i  (s_axi_rready_i),
        .rif       (rif.bus)
    );

    cmpref_regs u_regs (
        .clock_i                    (clock_i),
        .resetn_i                   (resetn_i),
        .cmp_out_i                  ({cmp_three_output_i, cmp_two_output_i, cmp_one_output_i}),
        .idle_i                     (idle_i),
        .rif                        (rif.regs),
        .stop_in_idle_o             (stop_in_idle_o),
        .cmp_enable_o               (cmp_enable_o),
        .ladder_enable_o            (ladder_enable_o),
        .ladder_pin_output_enable_o (ladder_pin_output_enable_o),
        .ladder_range_select_o      (ladder_range_select_o),
        .ladder_supply_select_o     (ladder_supply_select_o),
        .ladder_tap_select_o        (ladder_tap_select_o),
        .ladder_cmp_connect_o       (ladder_cmp_connect_o)
    );
endmodule // cmpref_top

// ---- test/test_cmpref_top.sv ----
// Self-checking bench for the comparator status and reference ladder register block
`timescale 1ns/1ps
module test_cmpref_top;
    import cmpref_pkg::*;
    logic        clock, resetn, awvalid, wvalid, bready, arvalid, rready, idle;
    logic [15:0] awaddr, araddr;
    logic [31:0] wdata, rdata, ctrl_m;
    logic [3:0]  wstrb, lad_tap;
    logic [1:0]  bresp, rresp, rsp;
    logic [2:0]  cmp;
    logic        awready, wready, bvalid, arready, rvalid, stop_m, rd_stop;
    logic        cmp_en, lad_en, lad_oe, lad_rng, lad_sup, lad_conn;
    logic [31:0] rd;
    int          fail_count, checks_done, seed;

    cmpref_top dut_u (.clock_i(clock), .resetn_i(resetn), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .cmp_one_output_i(cmp[0]), .cmp_two_output_i(cmp[1]),
        .cmp_three_output_i(cmp[2]), .idle_i(idle), .stop_in_idle_o(rd_stop),
        .cmp_enable_o(cmp_en), .ladder_enable_o(lad_en), .ladder_pin_output_enable_o(lad_oe),
        .ladder_range_select_o(lad_rng), .ladder_supply_select_o(lad_sup),
        .ladder_tap_select_o(lad_tap), .ladder_cmp_connect_o(lad_conn));

    // Free-running 50 MHz clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Write: address and data offered together, each dropped once taken
    task automatic axi_write(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] r);
        bit aw_p, w_p, done;
        aw_p = 1; w_p = 1; done = 0;
        @(posedge clock);
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1; bready <= 1'b1;
        while (!done) begin
            @(posedge clock);
            if (!aw_p && !w_p && bvalid === 1'b1) begin
                r = bresp; done = 1; bready <= 1'b0;
            end
            if (aw_p && awready === 1'b1) begin
                aw_p = 0; awvalid <= 1'b0;
            end
            if (w_p && wready === 1'b1) begin
                w_p = 0; wvalid <= 1'b0;
            end
        end
    endtask

    // Read: rready held with the request until rvalid is sampled
    task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ar_p, done;
        ar_p = 1; done = 0;
        @(posedge clock);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!done) begin
            @(posedge clock);
            if (!ar_p && rvalid === 1'b1) begin
                d = rdata; r = rresp; done = 1; rready <= 1'b0;
            end
            if (ar_p && arready === 1'b1) begin
                ar_p = 0; arvalid <= 1'b0;
            end
        end
    endtask

    // Model of plain, clear, set and invert writes with byte lanes
    task automatic ctrl_op(input int op, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] bm, dm;
        logic [1:0]  r;
        bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & REF_CTRL_MASK;
        dm = d & bm;
        axi_write(REF_CTRL_ADDR + 16'(op * 4), d, s, r);
        check_val("ctrl bresp", 32'(RESP_OKAY), 32'(r));
        case (op)
            0: ctrl_m = (ctrl_m & ~bm) | dm;
            1: ctrl_m = ctrl_m & ~dm;
            2: ctrl_m = ctrl_m | dm;
            default: ctrl_m = ctrl_m ^ dm;
        endcase
    endtask

    // Readback through any alias, then the decoded control outputs
    task automatic check_ctrl(input int a);
        axi_read(REF_CTRL_ADDR + 16'(a * 4), rd, rsp);
        check_val("ctrl read", ctrl_m, rd);
        check_val("ctrl rresp", 32'(RESP_OKAY), 32'(rsp));
        check_val("ladder enable", 32'(ctrl_m[15]), 32'(lad_en));
        check_val("pin enable", 32'(ctrl_m[6]), 32'(lad_oe));
        check_val("range", 32'(ctrl_m[5]), 32'(lad_rng));
        check_val("supply", 32'(ctrl_m[4]), 32'(lad_sup));
        check_val("tap", 32'(ctrl_m[3:0]), 32'(lad_tap));
        check_val("cmp connect", 32'h1, 32'(lad_conn));
    endtask

    task automatic check_stat();
        axi_read(CMP_STAT_ADDR, rd, rsp);
        check_val("status read", {18'h0, stop_m, 10'h0, cmp}, rd);
        check_val("status rresp", 32'(RESP_OKAY), 32'(rsp));
        check_val("stop output", 32'(stop_m), 32'(rd_stop));
    endtask

    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        print_verdict();
    end

    // Main sequence
    initial begin
        resetn = 1'b0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        awaddr = 0; araddr = 0; wdata = 0; wstrb = 0; cmp = 0; idle = 0;
        fail_count = 0; checks_done = 0; seed = 5; ctrl_m = 0; stop_m = 0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        check_ctrl(0);
        check_stat();
        check_val("cmp enable", 32'h1, 32'(cmp_en));
        // Random traffic through all four write kinds, some with partial lanes
        for (int i = 0; i < 48; i++) begin
            ctrl_op(i % 4, $random(seed), (i < 32) ? 4'hF : 4'($random(seed)));
            check_ctrl(i % 4);
        end
        // Unmapped place: refused, no side effect
        axi_write(16'h9820, 32'hFFFF_FFFF, 4'hF, rsp);
        check_val("unmapped bresp", 32'(RESP_SLVERR), 32'(rsp));
        axi_read(16'h9820, rd, rsp);
        check_val("unmapped rresp", 32'(RESP_SLVERR), 32'(rsp));
        check_val("unmapped rdata", 32'h0000_0000, rd);
        check_ctrl(0);
        // Status: only stop-in-idle takes a write, pins show through
        axi_write(CMP_STAT_ADDR, 32'hFFFF_FFFF, 4'hF, rsp);
        check_val("status bresp", 32'(RESP_OKAY), 32'(rsp));
        stop_m = 1'b1;
        for (int i = 0; i < 8; i++) begin
            cmp <= 3'(i);
            repeat (4) @(posedge clock);
            check_stat();
        end
        check_val("cmp enable awake", 32'h1, 32'(cmp_en));
        idle <= 1'b1;
        repeat (3) @(posedge clock);
        check_val("cmp enable idle stop", 32'h0, 32'(cmp_en));
        axi_write(CMP_STAT_ADDR, 32'h0, 4'h2, rsp);
        stop_m = 1'b0;
        repeat (3) @(posedge clock);
        check_val("cmp enable idle run", 32'h1, 32'(cmp_en));
        check_stat();
        idle <= 1'b0;
        // Reset in mid-run returns the control register to zero
        ctrl_op(2, 32'h0000_807F, 4'hF);
        check_ctrl(0);
        @(posedge clock);
        resetn <= 1'b0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        ctrl_m = 0;
        check_ctrl(0);
        check_stat();
        print_verdict();
    end
endmodule // test_cmpref_top
